// ===== hw/pif_pkg.sv
// constants for the port input, interrupt, filter and key reset block
// assumes an APB master and a 250 MHz core clock
// Overview of operation
// - per-pin interrupt allow bit, reset blocked
// - blocked pins never raise a request
// - per-pin edge select, 1 falling
// - flag sets on selected edge
// - flag and allow drive port request
// - write one clears flag, zero keeps
// - filter time per nibble, two fields
// - codes 1..7 select 256..16384 cycles
// - accept changes lasting one verification time
// - key reset selects two, three, four pins
// - all selected pins low fires reset
// - initial reset disables key reset
// - no key reset while sleeping
// - input gate forces read data zero
package pif_pkg;
	localparam int ADDR_W = 18;
	localparam int CNT_W = 15;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_P0_IN = 16'h5200;
	localparam logic [15:0] IDX_P0_ALLOW = 16'h5205;
	localparam logic [15:0] IDX_P0_POL = 16'h5206;
	localparam logic [15:0] IDX_P0_FLAGS = 16'h5207;
	localparam logic [15:0] IDX_P0_FILT = 16'h5208;
	localparam logic [15:0] IDX_P0_KEY = 16'h5209;
	localparam logic [15:0] IDX_P0_GATE = 16'h520a;
	localparam logic [15:0] IDX_P1_IN = 16'h5210;
	localparam logic [15:0] IDX_P1_ALLOW = 16'h5215;
	localparam logic [15:0] IDX_P1_POL = 16'h5216;
	localparam logic [15:0] IDX_P1_FLAGS = 16'h5217;
	localparam logic [15:0] IDX_P1_FILT = 16'h5218;
	localparam logic [15:0] IDX_P1_GATE = 16'h521a;
	localparam logic [15:0] IDX_P2_IN = 16'h5220;
	localparam logic [15:0] IDX_P2_GATE = 16'h522a;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h5230;
	localparam logic [15:0] IDX_IRQ_CLEAR = 16'h5231;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_GATE = 8'hff;
	localparam logic [1:0] RST_KRST = 2'h0;
	// field positions in the filter control and key reset registers
	localparam int CHAT_LO_POS = 0;
	localparam int CHAT_HI_POS = 4;
	localparam int KRST_POS = 0;
	// filter base time in core clock periods for code 1
	localparam int FILT_BASE_CYC = 256;
	// key reset select codes
	localparam logic [1:0] KRST_OFF = 2'h0;
	localparam logic [1:0] KRST_TWO = 2'h1;
	localparam logic [1:0] KRST_THREE = 2'h2;
	localparam logic [1:0] KRST_FOUR = 2'h3;
	// cycles after reset before edges are believed
	localparam logic [1:0] SETTLE_CYC = 2'h3;
endpackage

// ===== hw/pif_filter.sv
// chattering filter for one pin: counts cycles of a stable changed level
// assumes raw_i is already synchronised to core_clk_i
`timescale 1ns/1ns
module pif_filter (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic raw_i,
	input wire logic [pif_pkg::CNT_W-1:0] limit_i,
	output logic level_o
);
	logic [pif_pkg::CNT_W-1:0] count;
	logic primed;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			level_o <= 1'b0;
			count <= '0;
			primed <= 1'b0;
		end else if (!primed || limit_i == '0) begin
			// first cycle after reset takes the pin level without an edge
			level_o <= raw_i;
			count <= '0;
			primed <= 1'b1;
		end else if (raw_i == level_o) begin
			count <= '0;
		end else if (count >= limit_i - 1'b1) begin
			level_o <= raw_i;
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end
endmodule

// ===== hw/pif_top.sv
// port input block: pin sync, gates, filters, edge flags, key reset, APB
// assumes pins are asynchronous and sleep_i comes from core_clk_i logic
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module pif_top #(
	parameter int FILT_BASE = pif_pkg::FILT_BASE_CYC
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pif_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] p0_pin_i,
	input wire logic [7:0] p1_pin_i,
	input wire logic [7:0] p2_pin_i,
	input wire logic sleep_i,
	output logic p0_irq_o,
	output logic p1_irq_o,
	output logic irq_o,
	output logic key_reset_o
);
	logic [7:0] p0_irq_allow;
	logic [7:0] p1_irq_allow;
	logic [7:0] p0_irq_edge_select;
	logic [7:0] p1_irq_edge_select;
	logic [7:0] p0_irq_flags;
	logic [7:0] p1_irq_flags;
	logic [7:0] p0_debounce_control;
	logic [7:0] p1_debounce_control;
	logic [1:0] key_reset_pin_select;
	logic [7:0] p0_input_gate;
	logic [7:0] p1_input_gate;
	logic [7:0] p2_input_gate;
	logic [23:0] pin_meta;
	logic [23:0] pin_sync;
	logic [23:0] pin_gated;
	logic [15:0] filt_level;
	logic [15:0] filt_prev;
	logic [15:0] pin_event;
	logic [15:0] pin_edge_polarity;
	logic [15:0] pin_event_flag;
	logic [15:0] flag_clear;
	logic [1:0] settle;
	logic settled;
	logic wr_en;
	logic rd_setup;
	logic [7:0] rd_val;
	logic rd_hit;
	logic [3:0] key_mask;

	function automatic logic hit(input logic [pif_pkg::ADDR_W-1:0] a,
			input logic [15:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	function automatic logic [pif_pkg::CNT_W-1:0] filt_limit(
			input logic [2:0] code);
		logic [pif_pkg::CNT_W-1:0] base;
		base = pif_pkg::CNT_W'(FILT_BASE);
		if (code == 3'h0) begin
			filt_limit = '0;
		end else begin
			filt_limit = base << (code - 3'h1);
		end
	endfunction

	function automatic logic wr_hit(input logic en,
			input logic [pif_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
		wr_hit = en && hit(a, idx);
	endfunction

	// zero wait state slave; read data latched in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	// software register writes
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			p0_irq_allow <= pif_pkg::RST_ZERO;
			p1_irq_allow <= pif_pkg::RST_ZERO;
			p0_irq_edge_select <= pif_pkg::RST_ZERO;
			p1_irq_edge_select <= pif_pkg::RST_ZERO;
			p0_debounce_control <= pif_pkg::RST_ZERO;
			p1_debounce_control <= pif_pkg::RST_ZERO;
			p0_input_gate <= pif_pkg::RST_GATE;
			p1_input_gate <= pif_pkg::RST_GATE;
			p2_input_gate <= pif_pkg::RST_GATE;
		end else begin
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_ALLOW)) begin
				p0_irq_allow <= pwdata[7:0];
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P1_ALLOW)) begin
				p1_irq_allow <= pwdata[7:0];
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_POL)) begin
				p0_irq_edge_select <= pwdata[7:0];
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P1_POL)) begin
				p1_irq_edge_select <= pwdata[7:0];
			end
			// reserved bits 7 and 3 stay zero
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_FILT)) begin
				p0_debounce_control <= pwdata[7:0] & 8'h77;
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P1_FILT)) begin
				p1_debounce_control <= pwdata[7:0] & 8'h77;
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_GATE)) begin
				p0_input_gate <= pwdata[7:0];
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P1_GATE)) begin
				p1_input_gate <= pwdata[7:0];
			end
			if (wr_hit(wr_en, paddr, pif_pkg::IDX_P2_GATE)) begin
				p2_input_gate <= pwdata[7:0];
			end
		end
	end

	// key reset select has its own process; any initial reset disables it
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			key_reset_pin_select <= pif_pkg::RST_KRST;
		end else if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_KEY)) begin
			key_reset_pin_select <= pwdata[pif_pkg::KRST_POS +: 2];
		end
	end

	// two-stage pin synchroniser; first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {p2_pin_i, p1_pin_i, p0_pin_i};
			pin_sync <= pin_meta;
		end
	end

	// a closed gate reads as zero and also starves the filter
	assign pin_gated = pin_sync &
		{p2_input_gate, p1_input_gate, p0_input_gate};
	assign pin_edge_polarity = {p1_irq_edge_select, p0_irq_edge_select};

	// ignore edges until the synchroniser and filters hold real levels
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			settle <= 2'h0;
			settled <= 1'b0;
		end else begin
			// registered so the filters' first real level is not an edge
			if (settle != pif_pkg::SETTLE_CYC) begin
				settle <= settle + 2'h1;
			end
			settled <= (settle == pif_pkg::SETTLE_CYC);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_pin
			logic [2:0] code;
			logic [7:0] chat;
			assign chat = (g < 8) ? p0_debounce_control : p1_debounce_control;
			// one field per nibble of each port
			assign code = ((g % 8) < 4) ?
				chat[pif_pkg::CHAT_LO_POS +: 3] :
				chat[pif_pkg::CHAT_HI_POS +: 3];
			pif_filter u_filt (
				.core_clk_i(core_clk_i),
				.rstn_i(rstn_i),
				.raw_i(pin_gated[g]),
				.limit_i(filt_limit(code)),
				.level_o(filt_level[g])
			);
			// edge is taken from the filtered level
			assign pin_event[g] = settled && (pin_edge_polarity[g] ?
				(filt_prev[g] && !filt_level[g]) :
				(!filt_prev[g] && filt_level[g]));
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			filt_prev <= '0;
		end else begin
			filt_prev <= filt_level;
		end
	end

	// clear comes from the flag registers or the clear alias
	always_comb begin
		flag_clear = '0;
		if (wr_hit(wr_en, paddr, pif_pkg::IDX_P0_FLAGS)) begin
			flag_clear[7:0] = pwdata[7:0];
		end
		if (wr_hit(wr_en, paddr, pif_pkg::IDX_P1_FLAGS)) begin
			flag_clear[15:8] = pwdata[7:0];
		end
		if (wr_hit(wr_en, paddr, pif_pkg::IDX_IRQ_CLEAR)) begin
			flag_clear = flag_clear | pwdata[15:0];
		end
	end

	// a new edge in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pin_event_flag <= '0;
		end else begin
			pin_event_flag <= (pin_event_flag & ~flag_clear) | pin_event;
		end
	end
	assign p0_irq_flags = pin_event_flag[7:0];
	assign p1_irq_flags = pin_event_flag[15:8];

	// request follows the flag in the same cycle, gated by the allow bits
	assign p0_irq_o = |(p0_irq_flags & p0_irq_allow);
	assign p1_irq_o = |(p1_irq_flags & p1_irq_allow);
	assign irq_o = p0_irq_o || p1_irq_o;

	// key reset uses the ungated synchronised pins
	always_comb begin
		unique case (key_reset_pin_select)
			pif_pkg::KRST_TWO: key_mask = 4'h3;
			pif_pkg::KRST_THREE: key_mask = 4'h7;
			pif_pkg::KRST_FOUR: key_mask = 4'hf;
			pif_pkg::KRST_OFF: key_mask = 4'h0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			key_reset_o <= 1'b0;
		end else begin
			key_reset_o <= (key_mask != 4'h0) && !sleep_i &&
				((pin_sync[3:0] & key_mask) == 4'h0);
		end
	end

	// read mux
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		if (hit(paddr, pif_pkg::IDX_P0_IN)) begin
			rd_val = pin_gated[7:0];
		end else if (hit(paddr, pif_pkg::IDX_P1_IN)) begin
			rd_val = pin_gated[15:8];
		end else if (hit(paddr, pif_pkg::IDX_P2_IN)) begin
			rd_val = pin_gated[23:16];
		end else if (hit(paddr, pif_pkg::IDX_P0_ALLOW)) begin
			rd_val = p0_irq_allow;
		end else if (hit(paddr, pif_pkg::IDX_P1_ALLOW)) begin
			rd_val = p1_irq_allow;
		end else if (hit(paddr, pif_pkg::IDX_P0_POL)) begin
			rd_val = p0_irq_edge_select;
		end else if (hit(paddr, pif_pkg::IDX_P1_POL)) begin
			rd_val = p1_irq_edge_select;
		end else if (hit(paddr, pif_pkg::IDX_P0_FLAGS)) begin
			rd_val = p0_irq_flags;
		end else if (hit(paddr, pif_pkg::IDX_P1_FLAGS)) begin
			rd_val = p1_irq_flags;
		end else if (hit(paddr, pif_pkg::IDX_P0_FILT)) begin
			rd_val = p0_debounce_control;
		end else if (hit(paddr, pif_pkg::IDX_P1_FILT)) begin
			rd_val = p1_debounce_control;
		end else if (hit(paddr, pif_pkg::IDX_P0_KEY)) begin
			rd_val = {6'h00, key_reset_pin_select};
		end else if (hit(paddr, pif_pkg::IDX_P0_GATE)) begin
			rd_val = p0_input_gate;
		end else if (hit(paddr, pif_pkg::IDX_P1_GATE)) begin
			rd_val = p1_input_gate;
		end else if (hit(paddr, pif_pkg::IDX_P2_GATE)) begin
			rd_val = p2_input_gate;
		end else if (hit(paddr, pif_pkg::IDX_IRQ_STATUS)) begin
			rd_val = 8'h00;
		end else if (hit(paddr, pif_pkg::IDX_IRQ_CLEAR)) begin
			rd_val = 8'h00;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// response registered in the setup cycle, shown in the access cycle
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !rd_hit;
			if (rd_setup && hit(paddr, pif_pkg::IDX_IRQ_STATUS)) begin
				prdata <= {16'h0000, pin_event_flag};
			end else if (rd_setup) begin
				prdata <= {24'h00_0000, rd_val};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

// ===== test/pif_monitor.sv
// checker: port-level relations of the port input block
// assumes it is bound onto pif_top, one clock, synchronous reset
`timescale 1ns/1ns
module pif_monitor #(
	parameter int FILT_BASE = 256
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pif_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] p0_pin_i,
	input wire logic sleep_i,
	input wire logic p0_irq_o,
	input wire logic p1_irq_o,
	input wire logic irq_o,
	input wire logic key_reset_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	logic wr_acc;
	assign wr_acc = psel && penable && pwrite;
	a_irq_merge: assert property (
		irq_o == (p0_irq_o | p1_irq_o)) else $error("irq merge");
	// flags are sticky, so a request only drops after a write
	a_irq_drop_write: assert property (
		$fell(p0_irq_o) |-> $past(wr_acc)) else $error("irq drop");
	a_p0_flag_clear: assert property (
		wr_acc && paddr == {pif_pkg::IDX_P0_FLAGS, 2'b00} &&
		pwdata[7:0] == 8'hff |=> !p0_irq_o) else $error("p0 clear");
	a_alias_clear: assert property (
		wr_acc && paddr == {pif_pkg::IDX_IRQ_CLEAR, 2'b00} &&
		pwdata[15:0] == 16'hffff |=> !irq_o) else $error("alias clear");
	a_sleep_no_reset: assert property (
		sleep_i |=> !key_reset_o) else $error("key reset in sleep");
	// a window of three samples tolerates the sync depth
	a_key_needs_low: assert property (
		|$past(p0_pin_i[1:0], 2) && |$past(p0_pin_i[1:0], 3) &&
		|$past(p0_pin_i[1:0], 4) |-> !key_reset_o) else $error("key");
	a_quiet_release: assert property (
		$rose(rstn_i) |-> !key_reset_o && !irq_o) else $error("release");
	a_ready_access: assert property (
		psel && penable |-> pready) else $error("no ready");
	a_refuse_zero: assert property (
		psel && penable && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused data");
	c_key_reset: cover property (key_reset_o);
	c_irq: cover property ($rose(irq_o));
	c_refused: cover property (psel && penable && pslverr);
endmodule

bind pif_top pif_monitor #(.FILT_BASE(FILT_BASE)) mon_u (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .p0_pin_i(p0_pin_i), .sleep_i(sleep_i),
	.p0_irq_o(p0_irq_o), .p1_irq_o(p1_irq_o), .irq_o(irq_o),
	.key_reset_o(key_reset_o)
);

// ===== test/pif_pins.sv
// pin model: keys and signals on three ports, pulled high at rest
// assumes drive is called right after a rising clock edge
`timescale 1ns/1ns
module pif_pins (
	input wire logic core_clk_i,
	output logic [7:0] p0_o,
	output logic [7:0] p1_o,
	output logic [7:0] p2_o
);
	// pull-ups keep every key released, never all selected keys low
	initial begin
		p0_o = 8'hff;
		p1_o = 8'hff;
		p2_o = 8'hff;
	end
	// sets a port now and holds it for n cycles
	task automatic drive(input int pt, input logic [7:0] v, input int n);
		if (pt == 0) p0_o <= v;
		else if (pt == 1) p1_o <= v;
		else p2_o <= v;
		repeat (n) @(posedge core_clk_i);
	endtask
endmodule

// ===== test/tb_port_input_irq_filter_keyreset.sv
// bench: registers over APB, edge flags, filter, key reset, gates
// assumes pif_top with a short filter base and the pin model beside it
`timescale 1ns/1ns
module tb_port_input_irq_filter_keyreset;
	localparam int FB = 4;
	logic core_clk_i;
	logic rstn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [pif_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic sleep_i = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, p0_irq_o, p1_irq_o, irq_o, key_reset_o;
	wire [7:0] p0, p1, p2;
	logic [31:0] seed = 32'h0000_0035;
	logic [31:0] rd_d, v, e;
	logic rd_e;
	int mismatches = 0;
	int total_checks = 0;
	int i, c, b, pt, len;
	logic [15:0] ri [12] = '{pif_pkg::IDX_P0_ALLOW, pif_pkg::IDX_P0_POL,
		pif_pkg::IDX_P0_FLAGS, pif_pkg::IDX_P0_FILT, pif_pkg::IDX_P0_KEY,
		pif_pkg::IDX_P1_ALLOW, pif_pkg::IDX_P1_POL, pif_pkg::IDX_P1_FLAGS,
		pif_pkg::IDX_P1_FILT, pif_pkg::IDX_P0_GATE, pif_pkg::IDX_P1_GATE,
		pif_pkg::IDX_P2_GATE};
	logic [7:0] rm [12] = '{8'hff, 8'hff, 8'h00, 8'h77, 8'h03, 8'hff,
		8'hff, 8'h00, 8'h77, 8'hff, 8'hff, 8'hff};
	pif_top #(.FILT_BASE(FB)) dut_u (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p0_pin_i(p0), .p1_pin_i(p1), .p2_pin_i(p2),
		.sleep_i(sleep_i), .p0_irq_o(p0_irq_o), .p1_irq_o(p1_irq_o),
		.irq_o(irq_o), .key_reset_o(key_reset_o)
	);
	pif_pins pins_u (.core_clk_i(core_clk_i), .p0_o(p0), .p1_o(p1),
		.p2_o(p2));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int flen(input int code);
		return FB << (code - 1);
	endfunction
	function automatic logic [7:0] kmask(input int code);
		return code == 0 ? 8'h00 : (8'h02 << code) - 8'h01;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) mismatches++;
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_d, x);
	endtask
	task end_of_test();
		if (mismatches == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (30000) @(posedge core_clk_i);
		mismatches++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(posedge core_clk_i);
		for (i = 0; i < 12; i++) rchk(ri[i], i > 8 ? 255 : 0);
		for (i = 0; i < 12; i++) begin
			v = rnd();
			wr(ri[i], v);
			rchk(ri[i], v & {24'h00_0000, rm[i]});
			wr(ri[i], i > 8 ? 32'h0000_00ff : 32'h0000_0000);
		end
		repeat (8) @(posedge core_clk_i);
		wr(pif_pkg::IDX_P0_FLAGS, 32'h0000_00ff);
		wr(pif_pkg::IDX_IRQ_CLEAR, 32'h0000_ffff);
		rchk(pif_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
		rchk(16'h5201, 32'h0000_0000);
		chk(32'(rd_e), 32'h0000_0001);
		// allow is raised with the flag still set on purpose
		for (i = 0; i < 8; i++) begin
			v = rnd();
			pt = v[3];
			b = v[2:0];
			e = 32'h0000_0001 << (8 * pt + b);
			wr(pif_pkg::IDX_P0_POL + 16'(16 * pt), 32'(v[4]) << b);
			pins_u.drive(pt, ~(8'h01 << b), 8);
			rchk(pif_pkg::IDX_IRQ_STATUS, v[4] ? e : 0);
			pins_u.drive(pt, 8'hff, 8);
			rchk(pif_pkg::IDX_IRQ_STATUS, e);
			chk(32'(irq_o), 32'h0000_0000);
			wr(pif_pkg::IDX_P0_FLAGS + 16'(16 * pt), 32'h0000_0000);
			wr(pif_pkg::IDX_P0_ALLOW + 16'(16 * pt), e >> (8 * pt));
			chk(32'({p1_irq_o, p0_irq_o}), 32'h0000_0001 << pt);
			if (v[5]) wr(pif_pkg::IDX_IRQ_CLEAR, 32'h0000_ffff);
			else wr(pif_pkg::IDX_P0_FLAGS + 16'(16 * pt), 32'h0000_00ff);
			chk(32'(irq_o), 32'h0000_0000);
			wr(pif_pkg::IDX_P0_ALLOW + 16'(16 * pt), 32'h0000_0000);
		end
		// pin 1 filtered, pin 5 in the unfiltered nibble
		for (c = 1; c < 8; c++) begin
			pt = c % 2;
			len = flen(c);
			e = 32'h0000_0001 << (8 * pt);
			wr(pif_pkg::IDX_P0_FILT + 16'(16 * pt), 32'(c));
			repeat (2 * len + 8) @(posedge core_clk_i);
			wr(pif_pkg::IDX_IRQ_CLEAR, 32'h0000_ffff);
			pins_u.drive(pt, 8'hdd, 1);
			pins_u.drive(pt, 8'hfd, len - 2);
			pins_u.drive(pt, 8'hff, 2 * len + 8);
			rchk(pif_pkg::IDX_IRQ_STATUS, e << 5);
			pins_u.drive(pt, 8'hfd, 2 * len);
			pins_u.drive(pt, 8'hff, 2 * len + 8);
			rchk(pif_pkg::IDX_IRQ_STATUS, (e << 5) | (e << 1));
			wr(pif_pkg::IDX_P0_FILT + 16'(16 * pt), 32'h0000_0000);
		end
		for (c = 0; c < 4; c++) begin
			wr(pif_pkg::IDX_P0_KEY, 32'(c));
			pins_u.drive(0, ~kmask(c), 6);
			chk(32'(key_reset_o), 32'(c != 0));
			pins_u.drive(0, 8'hff ^ (kmask(c) >> 1), 6);
			chk(32'(key_reset_o), 32'h0000_0000);
			sleep_i <= 1'b1;
			pins_u.drive(0, ~kmask(c), 6);
			chk(32'(key_reset_o), 32'h0000_0000);
			sleep_i <= 1'b0;
			pins_u.drive(0, 8'hff, 6);
		end
		wr(pif_pkg::IDX_P0_KEY, 32'h0000_0000);
		for (pt = 0; pt < 3; pt++) begin
			v = rnd();
			wr(pif_pkg::IDX_P0_GATE + 16'(16 * pt), 32'(v[7:0]));
			pins_u.drive(pt, v[15:8], 6);
			rchk(pif_pkg::IDX_P0_IN + 16'(16 * pt), 32'(v[15:8] & v[7:0]));
			wr(pif_pkg::IDX_P0_GATE + 16'(16 * pt), 32'h0000_00ff);
			pins_u.drive(pt, 8'hff, 6);
		end
		end_of_test();
	end
endmodule
